// >>> design/line_drv_pkg.sv
package line_drv_pkg;

    // Frame length in bits: start + data + parity + stop, baud ticks of 16x
    localparam int unsigned DIV_W        = 16;
    localparam int unsigned TICK_W       = 24;
    localparam int unsigned OVERSAMPLE   = 16;
    localparam int unsigned START_BITS   = 1;
    localparam int unsigned MIN_DATA     = 5;
    localparam int unsigned MIN_STOP     = 1;
    localparam int unsigned LED_TIME_NS  = 20000000;
    localparam int unsigned CLK_NS       = 5;
    localparam int unsigned LED_CYCLES   = LED_TIME_NS / CLK_NS;
    localparam int unsigned LED_W        = 23;
    localparam logic [DIV_W-1:0] DIV_RESET = 16'h0001;

    typedef enum logic [1:0] {
        CFG_SIMPLEX_RX = 2'b00,
        CFG_SIMPLEX_TX = 2'b01,
        CFG_HALF       = 2'b10,
        CFG_FULL       = 2'b11
    } duplex_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SEND = 2'b01,
        ST_HOLD = 2'b10
    } drv_state_t;

    // UART side view of the transmitter and modem control
    typedef struct packed {
        logic             tx_pending;
        logic             tx_shift_empty;
        logic             rts;
        logic             txd;
        logic [DIV_W-1:0] divisor;
        logic [1:0]       word_len;
        logic             parity_en;
        logic             two_stop;
    } uart_side_t;

    // Strap configuration
    typedef struct packed {
        logic    auto_sel;
        logic    rts_sel;
        duplex_t duplex;
    } strap_t;

endpackage : line_drv_pkg

// >>> design/rs485_driver_enable_control.sv
// What this block does
// - The driver is on only while this node must send, and off otherwise.
// - Automatic mode turns the driver on as soon as a character is pending.
// - Automatic mode keeps the driver on one character after the last bit.
// - The hold time follows the programmed baud rate with no extra setting.
// - In request-to-send mode the driver follows the request-to-send bit.
// - Two indicators pulse on transmit and on receive line activity.
// - Simplex passes data one way only, transmit-only or receive-only.
// - Half duplex never transmits and receives at the same moment.
// - Full duplex sends and receives at once; reception never gates drive.
// - A two-wire port runs half duplex only.
// - Driver timing works from about 191 baud (divisor 65535 at the 5 ns clock) up to 12.5 Mbaud (divisor 1).
// - Only one driver control source is used, automatic or request-to-send.
module rs485_driver_enable_control (
    input  wire logic                    core_clk_in,
    input  wire logic                    rst_in,
    input  wire line_drv_pkg::uart_side_t uart_in,
    input  wire line_drv_pkg::strap_t    strap_in,
    input  wire logic                    line_rxd_in,
    output logic                         line_txd_out,
    output logic                         drv_en_out,
    output logic                         rcv_en_n_out,
    output logic                         uart_rxd_out,
    output logic                         tx_led_out,
    output logic                         rx_led_out,
    output logic                         cfg_error_out
);
    import line_drv_pkg::*;

    drv_state_t          state_q, state_d;
    logic [TICK_W-1:0]   hold_q, hold_d;
    logic [TICK_W-1:0]   char_cycles;
    logic [3:0]          frame_bits;
    logic                drv_q, drv_d;
    logic                txd_q, txd_d;
    logic                rxd_q, rxd_d;
    logic                rcv_en_n_q, rcv_en_n_d;
    logic                err_q, err_d;
    logic                tx_ok;
    logic                rx_ok;
    logic                auto_mode;
    logic                rts_mode;
    logic                want_drv;
    logic                rx_gate;

    // Frame length and character time in clock cycles
    always_comb begin
        frame_bits = 4'(START_BITS + MIN_DATA + MIN_STOP)
                   + {2'b00, uart_in.word_len}
                   + {3'b000, uart_in.parity_en}
                   + {3'b000, uart_in.two_stop};
        char_cycles = TICK_W'(uart_in.divisor) * TICK_W'(OVERSAMPLE)
                    * TICK_W'(frame_bits);
    end

    // Source selection; both or neither strapped is a fault
    always_comb begin
        auto_mode = strap_in.auto_sel && !strap_in.rts_sel;
        rts_mode  = strap_in.rts_sel && !strap_in.auto_sel;
        err_d     = strap_in.auto_sel == strap_in.rts_sel;
    end

    // Direction permissions per duplex setting
    always_comb begin
        tx_ok = 1'b0;
        rx_ok = 1'b0;
        case (strap_in.duplex)
            CFG_SIMPLEX_RX: rx_ok = 1'b1;
            CFG_SIMPLEX_TX: tx_ok = 1'b1;
            CFG_HALF: begin
                tx_ok = 1'b1;
                rx_ok = 1'b1;
            end
            CFG_FULL: begin
                tx_ok = 1'b1;
                rx_ok = 1'b1;
            end
            default: begin
                tx_ok = 1'b0;
                rx_ok = 1'b0;
            end
        endcase
    end

    // Automatic driver control
    always_comb begin
        state_d = state_q;
        hold_d  = hold_q;
        case (state_q)
            ST_IDLE: begin
                if (uart_in.tx_pending) begin
                    state_d = ST_SEND;
                end
            end
            ST_SEND: begin
                if (!uart_in.tx_pending && uart_in.tx_shift_empty) begin
                    state_d = ST_HOLD;
                    hold_d  = (char_cycles == '0) ? TICK_W'(1)
                                                  : char_cycles;
                end
            end
            ST_HOLD: begin
                if (uart_in.tx_pending) begin
                    state_d = ST_SEND;
                end else if (hold_q <= TICK_W'(1)) begin
                    state_d = ST_IDLE;
                    hold_d  = '0;
                end else begin
                    hold_d  = hold_q - TICK_W'(1);
                end
            end
            default: begin
                state_d = ST_IDLE;
                hold_d  = '0;
            end
        endcase
    end

    // Driver, receiver gating and data paths
    always_comb begin
        want_drv = 1'b0;
        if (auto_mode) begin
            want_drv = (state_d != ST_IDLE) || uart_in.tx_pending;
        end else if (rts_mode) begin
            want_drv = uart_in.rts;
        end
        drv_d = want_drv && tx_ok;
        if (strap_in.duplex == CFG_HALF) begin
            rcv_en_n_d = drv_d || !rx_ok;
        end else begin
            rcv_en_n_d = !rx_ok;
        end
        txd_d = drv_d ? uart_in.txd : 1'b1;
        rxd_d = rcv_en_n_d ? 1'b1 : line_rxd_in;
    end

    // Activity stretchers for the indicators
    assign rx_gate = !rcv_en_n_q;

    activity_stretch activity_stretch_tx (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .gate_in     (drv_q),
        .level_in    (txd_q),
        .led_out     (tx_led_out)
    );

    activity_stretch activity_stretch_rx (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .gate_in     (rx_gate),
        .level_in    (rxd_q),
        .led_out     (rx_led_out)
    );

    // Automatic control state
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            state_q <= ST_IDLE;
            hold_q  <= '0;
        end else begin
            state_q <= state_d;
            hold_q  <= hold_d;
        end
    end

    // Line side registers, all safe at reset: driver off, lines idle
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            drv_q      <= 1'b0;
            txd_q      <= 1'b1;
            rxd_q      <= 1'b1;
            rcv_en_n_q <= 1'b1;
        end else begin
            drv_q      <= drv_d;
            txd_q      <= txd_d;
            rxd_q      <= rxd_d;
            rcv_en_n_q <= rcv_en_n_d;
        end
    end

    // Strap fault flag
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            err_q <= 1'b0;
        end else begin
            err_q <= err_d;
        end
    end

    assign drv_en_out    = drv_q;
    assign line_txd_out  = txd_q;
    assign rcv_en_n_out  = rcv_en_n_q;
    assign uart_rxd_out  = rxd_q;
    assign cfg_error_out = err_q;

endmodule : rs485_driver_enable_control

// Holds an indicator on for a fixed span after each edge on a gated level
module activity_stretch #(
    parameter int unsigned WIDTH = line_drv_pkg::LED_W,
    parameter int unsigned SPAN  = line_drv_pkg::LED_CYCLES
) (
    input  wire logic core_clk_in,
    input  wire logic rst_in,
    input  wire logic gate_in,
    input  wire logic level_in,
    output logic      led_out
);
    import line_drv_pkg::*;

    logic [WIDTH-1:0] cnt_q, cnt_d;
    logic             seen_q, seen_d;
    logic             led_q, led_d;

    // Restart the span on every edge while the path is open
    always_comb begin
        cnt_d  = cnt_q;
        seen_d = level_in;
        if (gate_in && (level_in != seen_q)) begin
            cnt_d = WIDTH'(SPAN);
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - WIDTH'(1);
        end
        led_d = cnt_d != '0;
    end

    // Seen level resets to the idle line level so reset gives no false edge
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            cnt_q  <= '0;
            seen_q <= 1'b1;
            led_q  <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            seen_q <= seen_d;
            led_q  <= led_d;
        end
    end

    assign led_out = led_q;

endmodule : activity_stretch

// >>> verification/uart_tx_model.sv
module uart_tx_model (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        load_in,
    input  wire logic [7:0]  data_in,
    input  wire logic [23:0] char_cycles_in,
    output logic             pending_out,
    output logic             shift_empty_out,
    output logic             txd_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] cnt_q;
    logic [7:0]  sh_q;
    // Pending only when a character is loaded, idle otherwise
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pending_out <= 1'b0;
            shift_empty_out <= 1'b1;
            txd_out <= 1'b1;
            cnt_q <= '0;
        end else begin
            if (load_in) pending_out <= 1'b1;
            if (cnt_q != '0) begin
                cnt_q <= cnt_q - 24'h1;
                sh_q <= {~sh_q[0], sh_q[7:1]};
                txd_out <= (cnt_q == 24'h1) | sh_q[0];
                shift_empty_out <= (cnt_q == 24'h1);
            end else if (pending_out) begin
                pending_out <= load_in;
                shift_empty_out <= 1'b0;
                cnt_q <= char_cycles_in;
                sh_q <= data_in;
                txd_out <= 1'b0;
            end
        end
    end
endmodule : uart_tx_model

// >>> verification/rs485_driver_enable_control_assertions.sv
module drv_enable_checker (
    input wire logic                     core_clk_in,
    input wire logic                     rst_in,
    input wire line_drv_pkg::uart_side_t uart_in,
    input wire line_drv_pkg::strap_t     strap_in,
    input wire logic                     line_rxd_in,
    input wire logic                     line_txd_out,
    input wire logic                     drv_en_out,
    input wire logic                     rcv_en_n_out,
    input wire logic                     uart_rxd_out,
    input wire logic                     tx_led_out,
    input wire logic                     rx_led_out,
    input wire logic                     cfg_error_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import line_drv_pkg::*;
    logic              auto_m, rts_m, tx_ok, idle;
    logic [TICK_W-1:0] idle_q, idle_d;
    int unsigned       char_c;
    assign auto_m = strap_in.auto_sel & ~strap_in.rts_sel;
    assign rts_m = strap_in.rts_sel & ~strap_in.auto_sel;
    assign tx_ok = strap_in.duplex != CFG_SIMPLEX_RX;
    assign idle = ~uart_in.tx_pending & uart_in.tx_shift_empty;
    assign char_c = uart_in.divisor * OVERSAMPLE * (START_BITS + MIN_DATA
        + uart_in.word_len + uart_in.parity_en + MIN_STOP + uart_in.two_stop);
    always_comb idle_d = idle ? idle_q + 1'b1 : '0;
    always_ff @(posedge core_clk_in) idle_q <= rst_in ? '0 : idle_d;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    a_auto_on: assert property (auto_m && tx_ok && uart_in.tx_pending
        |=> drv_en_out) else $error("driver late");
    a_hold_time: assert property (auto_m && tx_ok && $fell(drv_en_out)
        |-> idle_q + 2 >= char_c && idle_q <= char_c + 4) else $error("hold");
    a_hold_max: assert property (auto_m && drv_en_out
        |-> idle_q <= char_c + 4) else $error("hold too long");
    a_rts_follow: assert property (rts_m && tx_ok
        |=> drv_en_out == $past(uart_in.rts)) else $error("rts follow");
    a_one_source: assert property (strap_in.auto_sel == strap_in.rts_sel
        |=> cfg_error_out && !drv_en_out) else $error("source select");
    a_rx_only: assert property (strap_in.duplex == CFG_SIMPLEX_RX
        |=> !drv_en_out && line_txd_out) else $error("rx only sent");
    a_half_excl: assert property (strap_in.duplex == CFG_HALF && drv_en_out
        |-> rcv_en_n_out) else $error("half duplex overlap");
    a_full_both: assert property (strap_in.duplex == CFG_FULL
        |=> !rcv_en_n_out && uart_rxd_out == $past(line_rxd_in))
        else $error("full duplex rx");
    a_txd_pass: assert property (drv_en_out && $past(drv_en_out)
        |-> line_txd_out == $past(uart_in.txd)) else $error("txd path");
    a_tx_led: assert property ($changed(line_txd_out)
        |-> ##[0:3] tx_led_out) else $error("tx led");
    a_rx_led: assert property (!rcv_en_n_out && $changed(uart_rxd_out)
        |-> ##[0:3] rx_led_out) else $error("rx led");
    c_auto_fall: cover property (auto_m && $fell(drv_en_out));
    c_rts_rise: cover property (rts_m && $rose(drv_en_out));
    c_cfg_err: cover property ($rose(cfg_error_out));
endmodule : drv_enable_checker

bind rs485_driver_enable_control drv_enable_checker drv_enable_checker_i (
    .core_clk_in, .rst_in, .uart_in, .strap_in, .line_rxd_in, .line_txd_out,
    .drv_en_out, .rcv_en_n_out, .uart_rxd_out, .tx_led_out, .rx_led_out,
    .cfg_error_out);

// >>> verification/rs485_driver_enable_control_bench.sv
module rs485_driver_enable_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import line_drv_pkg::*;
    logic             core_clk_in = 1'b0, rst_in = 1'b1;
    logic             load, rts, rxd, par, ts, pend, empty, txd;
    logic             line_txd, drv_en, rcv_en_n, uart_rxd, tx_led, rx_led, cfg_err;
    logic [7:0]       data;
    logic [1:0]       wl;
    logic [DIV_W-1:0] div;
    logic [23:0]      ctime;
    strap_t           strap;
    int               num_errors = 0, comparisons = 0;
    always #2.5 core_clk_in = ~core_clk_in;
    function automatic logic [23:0] char_time(input logic [DIV_W-1:0] d,
        input logic [1:0] w, input logic p, input logic s);
        return 24'(d * OVERSAMPLE * (START_BITS + MIN_DATA + w + p + MIN_STOP + s));
    endfunction : char_time
    assign ctime = char_time(div, wl, par, ts);
    uart_tx_model uart_tx_model_i (.clk_in(core_clk_in), .rst_in, .load_in(load),
        .data_in(data), .char_cycles_in(ctime), .pending_out(pend),
        .shift_empty_out(empty), .txd_out(txd));
    rs485_driver_enable_control rs485_driver_enable_control_i (.core_clk_in,
        .rst_in, .uart_in('{pend, empty, rts, txd, div, wl, par, ts}),
        .strap_in(strap), .line_rxd_in(rxd), .line_txd_out(line_txd),
        .drv_en_out(drv_en), .rcv_en_n_out(rcv_en_n), .uart_rxd_out(uart_rxd),
        .tx_led_out(tx_led), .rx_led_out(rx_led), .cfg_error_out(cfg_err));
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask : cyc
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    task automatic wait_en(input logic v, output int n);
        n = 0;
        while (drv_en !== v && n < 5000) begin
            @(negedge core_clk_in);
            n++;
        end
    endtask : wait_en
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    initial begin
        #500000;
        num_errors++;
        final_report();
    end
    initial begin
        int n;
        void'($urandom(32'habb0b10d));
        {load, rts, par, ts, wl, data} = '0;
        rxd = 1'b1;
        div = 16'h1;
        strap = '{1'b1, 1'b0, CFG_HALF};
        cyc(20);
        rst_in <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            cyc(5);
            div <= (i == 0) ? 16'h1 : 16'($urandom_range(3, 1));
            {wl, par, ts, data} <= 12'($urandom);
            cyc(2);
            load <= 1'b1;
            cyc(1);
            load <= i[0];
            cyc(1);
            load <= 1'b0;
            wait_en(1'b1, n);
            chk("driver on", 1'b1, n <= 3);
            n = 0;
            while (!(pend === 1'b0 && empty === 1'b1) && n < 5000) begin
                @(negedge core_clk_in);
                n++;
            end
            wait_en(1'b0, n);
            chk("hold", 1'b1, n + 2 >= ctime && n <= ctime + 4);
            chk("tx led", 1'b1, tx_led);
            chk("cfg ok", 1'b0, cfg_err);
        end
        $display("auto mode test done");
        cyc(1);
        strap <= '{1'b0, 1'b1, CFG_SIMPLEX_RX};
        for (int d = 0; d < 4; d++) begin
            cyc(1);
            strap.duplex <= duplex_t'(d);
            repeat (16) begin
                cyc(1);
                {rts, rxd} <= 2'($urandom);
            end
            for (int r = 1; r >= 0; r--) begin
                cyc(1);
                rts <= r[0];
                rxd <= ~rxd;
                cyc(3);
                @(negedge core_clk_in);
                chk("drv en", r[0] && d != 0, drv_en);
                chk("rcv en n", d == 1 || (d == 2 && r == 1), rcv_en_n);
            end
        end
        chk("rx pass", rxd, uart_rxd);
        chk("rx led", 1'b1, rx_led);
        $display("rts mode test done");
        for (int c = 0; c < 2; c++) begin
            cyc(1);
            strap <= '{c[0], c[0], CFG_FULL};
            rts <= 1'b1;
            load <= 1'b1;
            cyc(1);
            load <= 1'b0;
            cyc(3);
            @(negedge core_clk_in);
            chk("cfg error", 1'b1, cfg_err);
            chk("drv off", 1'b0, drv_en);
        end
        $display("source select test done");
        final_report();
    end
endmodule : rs485_driver_enable_control_bench
